// *** hdl/isappe_pkg.sv ***
// constants and types for the isa plug-and-play front end
package isappe_pkg;
  ////////////////////////////////////////////////////////////////////////
  // indexed register map
  localparam logic [7:0] REG_STATUS = 8'h05;
  localparam logic [7:0] REG_COMMAND = 8'hF0;
  localparam logic [7:0] REG_WORD_ADDR = 8'hF1;
  localparam logic [7:0] REG_DATA_HIGH = 8'hF2;
  localparam logic [7:0] REG_DATA_LOW = 8'hF3;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  // command fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_GO_BIT = 2;
  localparam int CMD_A8_BIT = 7;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam int STATUS_DONE_BIT = 0;
  ////////////////////////////////////////////////////////////////////////
  // modes
  localparam logic [1:0] MODE_DMA = 2'h0;
  localparam logic [1:0] MODE_EXT_INT = 2'h1;
  localparam int DMA_MODE_IRQ_LINES = 6;
  localparam int DMA_MODE_CS_COUNT = 2;
  localparam int CS_COUNT = 4;
  localparam int CS_ADDR_BITS = 14;
  localparam int CS_WINDOW_BITS = 3;
  ////////////////////////////////////////////////////////////////////////
  // nonvolatile array
  localparam int WORD_BITS = 16;
  localparam int ARRAY_WORDS = 384;
  localparam int SERIAL_WORDS = 256;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // serial command set
  localparam int SER_CMD_BITS = 10;
  localparam logic [1:0] SER_OP_READ = 2'h2;
  localparam logic [1:0] SER_OP_WRITE = 2'h1;
  localparam logic [1:0] SER_OP_ERASE = 2'h3;
  localparam logic [1:0] SER_EXT_ENABLE = 2'h3;
  localparam logic [1:0] SER_EXT_DISABLE = 2'h0;
  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLOCK_HZ = 100_000_000;
  localparam int PROG_TIME_MS = 10;
  localparam int PROG_CYCLES = PROG_TIME_MS * (CLOCK_HZ / 1000);
  typedef enum logic [4:0] {
    SER_IDLE = 5'h01,
    SER_CMD = 5'h02,
    SER_DATA = 5'h04,
    SER_OUT = 5'h08,
    SER_DONE = 5'h10
  } isappe_ser_state_t;
endpackage

// *** hdl/isappe_top.sv ***
// isa plug-and-play routing, chip selects and nonvolatile array
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// What this block does
// RQ1 - mode select input picks dma mode or extended interrupt mode
// RQ2 - dma mode: onboard dma request goes to one of two bus channels
// RQ3 - dma mode: each onboard interrupt steers to one of six bus lines
// RQ4 - dma mode: two programmable io chip selects
// RQ5 - extended mode: each onboard interrupt steers to one of eight lines
// RQ6 - extended mode: four programmable io chip selects
// RQ7 - extended mode: address bits 12 and 13 join chip select decode
// RQ8 - each chip select decodes address alone or qualified by strobe
// RQ9 - 6k bit array, lower 4k bits reachable over serial port
// RQ10 - serial port behaves as a standard four-wire serial memory
// RQ11 - whole array readable and programmable from the bus host
// RQ12 - programming registers only reachable in configuration state
// RQ13 - host loads low data byte at f3 and high byte at f2
// RQ14 - host places low eight word address bits at f1
// RQ15 - ninth word address bit comes from command bit 7
// RQ16 - command bits 1:0: 10 reads, 01 writes the addressed word
// RQ17 - operation starts only when go-ahead bit 2 is written as 1
// RQ18 - host writes zero to command bits 6 to 3
// RQ19 - word programming takes 10 ms; host waits or polls
// RQ20 - pollable indication active while operation runs
// RQ21 - status bit 0 at index 05: 0 busy, 1 done
// RQ22 - resource data sits in upper half; host sets ninth bit
// RQ23 - shared pin is dma request in, or chip select 2 output
// RQ24 - shared pins are bus dma acknowledges, or address bits 12, 13
// RQ25 - go-ahead ignored while busy; busy clears after storage cycle
module isappe_top import isappe_pkg::*; #(
  parameter int PROG_COUNT = PROG_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // indexed register port
  input wire logic i_config_state,
  input wire logic [7:0] i_reg_index,
  input wire logic i_reg_wr_stb,
  input wire logic i_reg_rd_stb,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // routing configuration
  input wire logic [1:0] i_mode_select,
  input wire logic [2:0] i_irq_sel0,
  input wire logic [2:0] i_irq_sel1,
  input wire logic i_dma_sel,
  input wire logic [CS_COUNT*CS_ADDR_BITS-1:0] i_cs_base,
  input wire logic [CS_COUNT-1:0] i_cs_enable,
  input wire logic [CS_COUNT-1:0] i_cs_qualify,
  // isa bus
  input wire logic [11:0] i_isa_addr,
  input wire logic i_ior_n,
  input wire logic i_iow_n,
  input wire logic i_aen,
  input wire logic [1:0] i_bus_dack_sa_n,
  output logic [5:0] o_bus_interrupt_out,
  output logic [1:0] o_bus_dma_irqhi,
  // on-board logic
  input wire logic [1:0] i_onboard_interrupt_in,
  input wire logic i_drq_cs2_in,
  output logic o_drq_cs2_n,
  output logic o_drq_cs2_oe,
  output logic o_dack_cs3_n,
  output logic [1:0] o_io_chip_select_n,
  // serial port
  input wire logic i_serial_select,
  input wire logic i_serial_clock,
  input wire logic i_serial_data_in,
  output logic o_serial_data_out
);
  localparam int CNT_W = $clog2(PROG_COUNT + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PROG_COUNT - 1);
  if (PROG_COUNT < 2) begin : g_bad_count
    $error("PROG_COUNT must be at least 2");
  end
  function automatic logic cs_hit(input logic [13:0] base,
                                  input logic [13:0] addr,
                                  input logic ext);
    logic [13:0] care;
    care = ext ? 14'h3FFF : 14'h0FFF;
    care = care & ~14'((1 << CS_WINDOW_BITS) - 1);
    return ((base ^ addr) & care) == 14'h0000;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // routing and chip selects
  logic ext_mode;
  logic [7:0] irq_d;
  logic [1:0] drq_d;
  logic [CS_COUNT-1:0] cs_act;
  logic [13:0] dec_addr;
  assign ext_mode = (i_mode_select == MODE_EXT_INT); // [RQ1]
  // shared pins carry address in extended mode only
  assign dec_addr = ext_mode ? {i_bus_dack_sa_n, i_isa_addr}
                             : {2'h0, i_isa_addr}; // [RQ7] [RQ24]
  always_comb begin
    irq_d = 8'h00;
    drq_d = 2'h0;
    if (i_onboard_interrupt_in[0] &&
        (ext_mode || i_irq_sel0 < 3'(DMA_MODE_IRQ_LINES))) begin
      irq_d[i_irq_sel0] = 1'b1; // [RQ3] [RQ5]
    end
    if (i_onboard_interrupt_in[1] &&
        (ext_mode || i_irq_sel1 < 3'(DMA_MODE_IRQ_LINES))) begin
      irq_d[i_irq_sel1] = 1'b1; // [RQ3] [RQ5]
    end
    if (!ext_mode) begin
      drq_d[i_dma_sel] = i_drq_cs2_in; // [RQ2] [RQ23]
    end
  end
  for (genvar k = 0; k < CS_COUNT; k++) begin : g_cs
    logic live;
    assign live = ext_mode || (k < DMA_MODE_CS_COUNT); // [RQ4] [RQ6]
    assign cs_act[k] = live && i_cs_enable[k] && !i_aen &&
      cs_hit(i_cs_base[k*CS_ADDR_BITS +: CS_ADDR_BITS], dec_addr,
             ext_mode) &&
      (!i_cs_qualify[k] || !i_ior_n || !i_iow_n); // [RQ8]
  end
  // registered pins trade one cycle of latency for glitch-free outputs
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_bus_interrupt_out <= 6'h00;
      o_bus_dma_irqhi <= 2'h0;
      o_drq_cs2_n <= 1'b1;
      o_drq_cs2_oe <= 1'b0;
      o_dack_cs3_n <= 1'b1;
      o_io_chip_select_n <= 2'h3;
    end else begin
      o_bus_interrupt_out <= irq_d[5:0];
      o_bus_dma_irqhi <= ext_mode ? irq_d[7:6] : drq_d; // [RQ5] [RQ2]
      o_drq_cs2_n <= !cs_act[2]; // [RQ23]
      o_drq_cs2_oe <= ext_mode; // [RQ23]
      o_dack_cs3_n <= ext_mode ? !cs_act[3]
                              : i_bus_dack_sa_n[i_dma_sel]; // [RQ24]
      o_io_chip_select_n <= ~cs_act[1:0]; // [RQ4]
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // host programming registers
  logic [7:0] cmd_q, addr_q, dhi_q, dlo_q;
  logic busy_q;
  logic [CNT_W-1:0] cnt_q;
  logic [WORD_BITS-1:0] mem_q [ARRAY_WORDS];
  logic reg_wr, reg_rd, cmd_go, host_rd, host_wr;
  logic [8:0] host_idx;
  logic host_in_range;
  logic ser_wr_start;
  logic [7:0] ser_wr_addr;
  logic [WORD_BITS-1:0] ser_wr_data;
  assign reg_wr = i_reg_wr_stb && i_config_state; // [RQ12]
  assign reg_rd = i_reg_rd_stb && i_config_state; // [RQ12]
  assign cmd_go = reg_wr && i_reg_index == REG_COMMAND &&
                  i_reg_wdata[CMD_GO_BIT] && !busy_q; // [RQ17] [RQ25]
  assign host_idx = {i_reg_wdata[CMD_A8_BIT], addr_q}; // [RQ15]
  assign host_in_range = host_idx < 9'(ARRAY_WORDS);
  assign host_rd = cmd_go && host_in_range &&
    i_reg_wdata[CMD_OP_LSB +: 2] == OP_READ; // [RQ16] [RQ11]
  assign host_wr = cmd_go && host_in_range &&
    i_reg_wdata[CMD_OP_LSB +: 2] == OP_WRITE; // [RQ16] [RQ11]
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cmd_q <= REG_RESET_VALUE;
      addr_q <= REG_RESET_VALUE;
      dhi_q <= REG_RESET_VALUE;
      dlo_q <= REG_RESET_VALUE;
    end else begin
      if (reg_wr && i_reg_index == REG_COMMAND) cmd_q <= i_reg_wdata;
      if (reg_wr && i_reg_index == REG_WORD_ADDR) addr_q <= i_reg_wdata;
      if (host_rd) begin
        {dhi_q, dlo_q} <= mem_q[host_idx]; // [RQ11]
      end else begin
        if (reg_wr && i_reg_index == REG_DATA_HIGH) dhi_q <= i_reg_wdata;
        if (reg_wr && i_reg_index == REG_DATA_LOW) dlo_q <= i_reg_wdata;
      end
    end
  end
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (i_reg_index)
        REG_STATUS: o_reg_rdata <= 8'(!busy_q); // [RQ21]
        REG_COMMAND: o_reg_rdata <= cmd_q;
        REG_WORD_ADDR: o_reg_rdata <= addr_q;
        REG_DATA_HIGH: o_reg_rdata <= dhi_q;
        REG_DATA_LOW: o_reg_rdata <= dlo_q;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end
  // one programming timer serves both the host and the serial port
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (host_wr || ser_wr_start) begin
      busy_q <= 1'b1; // [RQ20]
      cnt_q <= CNT_LOAD; // [RQ19]
    end else if (busy_q) begin
      if (cnt_q == '0) busy_q <= 1'b0; // [RQ25]
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end
  // contents survive reset, as the array is nonvolatile
  always_ff @(posedge i_clock) begin
    if (host_wr) begin
      mem_q[host_idx] <= {dhi_q, dlo_q}; // [RQ9] [RQ11]
    end else if (ser_wr_start) begin
      mem_q[ser_wr_addr] <= ser_wr_data; // [RQ9]
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // serial memory port, lower 256 words only
  isappe_ser_state_t st_q;
  logic sk_q, wen_q;
  logic [15:0] sh_q;
  logic [4:0] bit_q;
  logic [7:0] saddr_q;
  logic sk_rise, last_cmd, last_data, erase_go;
  logic [SER_CMD_BITS-1:0] ser_cmd;
  assign sk_rise = i_serial_clock && !sk_q;
  assign ser_cmd = {sh_q[8:0], i_serial_data_in};
  assign last_cmd = st_q == SER_CMD && sk_rise && bit_q == 5'h09;
  assign last_data = st_q == SER_DATA && sk_rise && bit_q == 5'h0F;
  assign erase_go = last_cmd && ser_cmd[9:8] == SER_OP_ERASE;
  // host wins a same-cycle start; the serial request is dropped
  assign ser_wr_start = i_serial_select && wen_q && !busy_q && !host_wr &&
                        (erase_go || last_data); // [RQ10]
  assign ser_wr_addr = erase_go ? ser_cmd[7:0] : saddr_q;
  assign ser_wr_data = erase_go ? ERASED_WORD
                                : {sh_q[14:0], i_serial_data_in};
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= SER_IDLE;
      sk_q <= 1'b0;
      wen_q <= 1'b0;
      sh_q <= 16'h0000;
      bit_q <= 5'h00;
      saddr_q <= 8'h00;
      o_serial_data_out <= 1'b0;
    end else begin
      sk_q <= i_serial_clock;
      if (!i_serial_select) begin
        st_q <= SER_IDLE;
        o_serial_data_out <= 1'b0;
      end else begin
        case (st_q)
          SER_IDLE: begin
            o_serial_data_out <= !busy_q; // [RQ10]
            if (sk_rise && i_serial_data_in) begin
              st_q <= SER_CMD;
              bit_q <= 5'h00;
            end
          end
          SER_CMD: if (sk_rise) begin
            sh_q <= {sh_q[14:0], i_serial_data_in};
            bit_q <= bit_q + 5'h01;
            if (last_cmd) begin
              saddr_q <= ser_cmd[7:0];
              bit_q <= 5'h00;
              st_q <= SER_DONE;
              case (ser_cmd[9:8])
                SER_OP_READ: begin
                  sh_q <= mem_q[ser_cmd[7:0]]; // [RQ9]
                  o_serial_data_out <= 1'b0; // dummy bit
                  st_q <= SER_OUT;
                end
                SER_OP_WRITE: st_q <= SER_DATA;
                SER_OP_ERASE: st_q <= SER_DONE;
                default: begin
                  if (ser_cmd[7:6] == SER_EXT_ENABLE) wen_q <= 1'b1;
                  if (ser_cmd[7:6] == SER_EXT_DISABLE) wen_q <= 1'b0;
                end
              endcase
            end
          end
          SER_DATA: if (sk_rise) begin
            sh_q <= {sh_q[14:0], i_serial_data_in};
            bit_q <= bit_q + 5'h01;
            if (last_data) st_q <= SER_DONE;
          end
          SER_OUT: if (sk_rise) begin
            o_serial_data_out <= sh_q[15];
            sh_q <= {sh_q[14:0], 1'b0};
            bit_q <= bit_q + 5'h01;
            if (bit_q == 5'h0F) st_q <= SER_DONE;
          end
          SER_DONE: st_q <= SER_DONE;
          default: st_q <= SER_IDLE;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb_chk @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence seq_host_write;
    host_wr;
  endsequence
  sequence seq_busy_run;
    busy_q [*8];
  endsequence
  AST_WRITE_BUSY: assert property (seq_host_write |=> seq_busy_run) // [RQ20]
    else $error("busy did not hold after write start");
  AST_BUSY_DONE: assert property (busy_q && cnt_q == '0 |=> !busy_q) // [RQ19]
    else $error("busy did not clear at end of count");
  AST_GO_IGNORED: assert property (busy_q && cnt_q != '0 && // [RQ25]
    reg_wr && i_reg_index == REG_COMMAND
    |=> cnt_q == $past(cnt_q) - CNT_W'(1))
    else $error("go-ahead restarted a busy operation");
  AST_NO_GO: assert property (!busy_q && !ser_wr_start && reg_wr && // [RQ17]
    i_reg_index == REG_COMMAND && !i_reg_wdata[CMD_GO_BIT] |=> !busy_q)
    else $error("operation started without go-ahead");
  AST_STATUS_POLARITY: assert property (reg_rd && // [RQ21]
    i_reg_index == REG_STATUS |=>
    o_reg_rdata[STATUS_DONE_BIT] == !$past(busy_q))
    else $error("status bit polarity wrong");
  AST_CONFIG_GATE: assert property (!i_config_state && i_reg_wr_stb // [RQ12]
    |=> $stable(cmd_q) && $stable(addr_q))
    else $error("register written outside config state");
  AST_IRQ_ROUTE: assert property (i_onboard_interrupt_in[0] && // [RQ3]
    i_irq_sel0 == 3'h3 |=> o_bus_interrupt_out[3])
    else $error("interrupt not steered to line 3");
  AST_EXT_IRQ7: assert property (ext_mode && // [RQ5]
    i_onboard_interrupt_in[1] && i_irq_sel1 == 3'h7 |=> o_bus_dma_irqhi[1])
    else $error("interrupt not steered to line 7");
  AST_DMA_ROUTE: assert property (!ext_mode && i_drq_cs2_in // [RQ2]
    |=> o_bus_dma_irqhi[$past(i_dma_sel)])
    else $error("dma request not routed");
  AST_CS_QUAL: assert property (i_cs_qualify[1] && i_ior_n && i_iow_n // [RQ8]
    |=> o_io_chip_select_n[1])
    else $error("qualified chip select active without strobe");
endmodule

// *** testbench/isappe_card_host.sv ***
// card-side serial master model for the nonvolatile serial port
`timescale 1ns/1ns
module isappe_card_host (
  // clock
  input wire logic i_clock,
  // serial port
  input wire logic i_serial_data_out,
  output logic o_serial_select = 1'b0,
  output logic o_serial_clock = 1'b0,
  output logic o_serial_data_in = 1'b0
);
  ////////////////////////////////////////////////////////////////////////
  // one frame of n bits, msb first; rx holds data out after each rise
  task automatic frame(input logic [26:0] tx, input int n,
                       output logic [26:0] rx);
    rx = '0;
    @(negedge i_clock);
    o_serial_select = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_data_in = tx[i]; // start, op, address, data
      repeat (2) @(negedge i_clock);
      o_serial_clock = 1'b1;
      // slow clock: data out updates on the first clock edge after the rise, half a cycle later
      repeat (3) @(negedge i_clock);
      rx = {rx[25:0], i_serial_data_out};
      o_serial_clock = 1'b0; // parked low outside frames
    end
    repeat (2) @(negedge i_clock);
    o_serial_select = 1'b0; // select drops between commands
    o_serial_data_in = 1'b0;
    repeat (2) @(negedge i_clock);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // ready poll: idle with select high shows not busy on data out
  task automatic wait_ready(output logic ok);
    ok = 1'b0;
    @(negedge i_clock);
    o_serial_select = 1'b1;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(negedge i_clock);
      ok = (i_serial_data_out === 1'b1);
    end
    o_serial_select = 1'b0;
    @(negedge i_clock);
  endtask
endmodule

// *** testbench/test_isappe.sv ***
// self-checking bench for the isa plug-and-play front end
`timescale 1ns/1ns
module test_isappe import isappe_pkg::*; ;
  localparam int PROG_SIM = 20;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_config_state = 1'b0;
  logic [7:0] i_reg_index = 8'h00;
  logic i_reg_wr_stb = 1'b0;
  logic i_reg_rd_stb = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata;
  logic [1:0] i_mode_select = 2'h0;
  logic [2:0] i_irq_sel0 = 3'h0;
  logic [2:0] i_irq_sel1 = 3'h0;
  logic i_dma_sel = 1'b0;
  logic [CS_COUNT*CS_ADDR_BITS-1:0] i_cs_base =
    {14'h0400, 14'h3200, 14'h0310, 14'h0300};
  logic [CS_COUNT-1:0] i_cs_enable = 4'hF;
  logic [CS_COUNT-1:0] i_cs_qualify = 4'h2;
  logic [11:0] i_isa_addr = 12'h000;
  logic i_ior_n = 1'b1;
  logic i_iow_n = 1'b1;
  logic i_aen = 1'b0;
  logic [1:0] i_bus_dack_sa_n = 2'h3;
  logic [5:0] o_bus_interrupt_out;
  logic [1:0] o_bus_dma_irqhi;
  logic [1:0] i_onboard_interrupt_in = 2'h0;
  logic i_drq_cs2_in = 1'b0;
  logic o_drq_cs2_n, o_drq_cs2_oe, o_dack_cs3_n;
  logic [1:0] o_io_chip_select_n;
  logic ser_sel, ser_clk, ser_din, ser_dout, ok;
  logic [26:0] rx;
  logic [7:0] exp8;
  int fail_count = 0;
  int tests_run = 0;

  always #5 i_clock = ~i_clock;

  isappe_top #(.PROG_COUNT(PROG_SIM)) uut (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_config_state(i_config_state),
    .i_reg_index(i_reg_index), .i_reg_wr_stb(i_reg_wr_stb),
    .i_reg_rd_stb(i_reg_rd_stb), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_mode_select(i_mode_select),
    .i_irq_sel0(i_irq_sel0), .i_irq_sel1(i_irq_sel1),
    .i_dma_sel(i_dma_sel), .i_cs_base(i_cs_base),
    .i_cs_enable(i_cs_enable), .i_cs_qualify(i_cs_qualify),
    .i_isa_addr(i_isa_addr), .i_ior_n(i_ior_n), .i_iow_n(i_iow_n),
    .i_aen(i_aen), .i_bus_dack_sa_n(i_bus_dack_sa_n),
    .o_bus_interrupt_out(o_bus_interrupt_out),
    .o_bus_dma_irqhi(o_bus_dma_irqhi),
    .i_onboard_interrupt_in(i_onboard_interrupt_in),
    .i_drq_cs2_in(i_drq_cs2_in), .o_drq_cs2_n(o_drq_cs2_n),
    .o_drq_cs2_oe(o_drq_cs2_oe), .o_dack_cs3_n(o_dack_cs3_n),
    .o_io_chip_select_n(o_io_chip_select_n),
    .i_serial_select(ser_sel), .i_serial_clock(ser_clk),
    .i_serial_data_in(ser_din), .o_serial_data_out(ser_dout));

  isappe_card_host card (.i_clock(i_clock), .i_serial_data_out(ser_dout),
    .o_serial_select(ser_sel), .o_serial_clock(ser_clk),
    .o_serial_data_in(ser_din));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(negedge i_clock);
    i_reg_index = idx;
    i_reg_wdata = d;
    i_reg_wr_stb = 1'b1;
    @(negedge i_clock);
    i_reg_wr_stb = 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    @(negedge i_clock);
    i_reg_index = idx;
    i_reg_rd_stb = 1'b1;
    @(negedge i_clock);
    i_reg_rd_stb = 1'b0;
    @(negedge i_clock);
    d = o_reg_rdata;
  endtask
  task automatic rdc(input string name, input logic [7:0] idx,
                     input logic [7:0] exp);
    logic [7:0] d;
    rd(idx, d);
    check(name, {8'h00, d}, {8'h00, exp});
  endtask
  // host side loads address and data before the go write
  task automatic prog(input logic [8:0] a, input logic [15:0] d,
                      input logic [1:0] op);
    wr(REG_WORD_ADDR, a[7:0]);
    wr(REG_DATA_HIGH, d[15:8]);
    wr(REG_DATA_LOW, d[7:0]);
    wr(REG_COMMAND, {a[8], 4'h0, 1'b1, op}); // reserved zero
  endtask
  task automatic wait_done();
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 50 && d[STATUS_DONE_BIT] !== 1'b1; i++) begin
      rd(REG_STATUS, d);
    end
    if (d[STATUS_DONE_BIT] !== 1'b1) begin
      fail_count++;
      $display("[ERR] status expected done seen %h", d);
      results();
    end
  endtask
  task automatic settle();
    repeat (2) @(negedge i_clock);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    i_sys_rst = 1'b0;
    i_config_state = 1'b1;
    rdc("status idle", REG_STATUS, 8'h01);
    rdc("addr reset", REG_WORD_ADDR, REG_RESET_VALUE);
    rdc("unmapped", 8'h40, 8'h00);
    wr(REG_STATUS, 8'hFE);
    rdc("status ro", REG_STATUS, 8'h01);
    @(negedge i_clock);
    i_config_state = 1'b0;
    wr(REG_WORD_ADDR, 8'h77);
    i_config_state = 1'b1;
    rdc("gated write", REG_WORD_ADDR, 8'h00);
    prog(9'h010, 16'hA53C, OP_WRITE);
    rdc("status busy", REG_STATUS, 8'h00);
    wr(REG_COMMAND, 8'h86); // read of a still unwritten word
    rdc("go while busy", REG_DATA_HIGH, 8'hA5);
    wait_done();
    prog(9'h110, 16'h5AC3, OP_WRITE); // upper half
    wait_done();
    wr(REG_COMMAND, 8'h01);
    rdc("no go", REG_STATUS, 8'h01);
    rdc("command rw", REG_COMMAND, 8'h01);
    prog(9'h010, 16'h0000, OP_READ);
    rdc("low hi", REG_DATA_HIGH, 8'hA5);
    rdc("low lo", REG_DATA_LOW, 8'h3C);
    prog(9'h110, 16'h0000, OP_READ);
    rdc("upper hi", REG_DATA_HIGH, 8'h5A);
    rdc("upper lo", REG_DATA_LOW, 8'hC3);
    // serial port: read host word, enable, write, host reads back
    card.frame({3'b110, 8'h10, 16'h0000}, 27, rx);
    check("ser read", rx[15:0], 16'hA53C);
    check("ser dummy", {15'h0, rx[16]}, 16'h0000);
    card.frame({16'h0, 3'b100, 8'hC0}, 11, rx);
    card.frame({3'b101, 8'h20, 16'h1234}, 27, rx);
    card.wait_ready(ok);
    check("ser ready", {15'h0, ok}, 16'h0001);
    prog(9'h020, 16'h0000, OP_READ);
    rdc("ser wr hi", REG_DATA_HIGH, 8'h12);
    rdc("ser wr lo", REG_DATA_LOW, 8'h34);
    // erase, then a write refused once writes are disabled again
    card.frame({16'h0, 3'b111, 8'h20}, 11, rx);
    card.wait_ready(ok);
    check("erase ready", {15'h0, ok}, 16'h0001);
    card.frame({16'h0, 3'b100, 8'h00}, 11, rx);
    card.frame({3'b101, 8'h20, 16'h1234}, 27, rx);
    card.frame({3'b110, 8'h20, 16'h0000}, 27, rx);
    check("ser erase", rx[15:0], ERASED_WORD);
    // irq steering, every select in both modes
    for (int m = 0; m < 2; m++) begin
      for (int n = 0; n < 2; n++) begin
        for (int s = 0; s < 8; s++) begin
          i_mode_select = m[1:0];
          i_irq_sel0 = s[2:0];
          i_irq_sel1 = s[2:0];
          i_onboard_interrupt_in = 2'b01 << n;
          settle();
          exp8 = (m == 1 || s < 6) ? 8'h01 << s : 8'h00;
          check("irq", {8'h0, o_bus_dma_irqhi, o_bus_interrupt_out},
                {8'h0, exp8});
        end
      end
    end
    i_mode_select = MODE_DMA;
    i_onboard_interrupt_in = 2'b00;
    i_drq_cs2_in = 1'b1;
    for (int d = 0; d < 2; d++) begin
      i_dma_sel = d[0];
      i_bus_dack_sa_n = ~(2'b01 << d);
      settle();
      check("dma", {14'h0, o_bus_dma_irqhi}, 16'h1 << d);
      check("dack lo", {15'h0, o_dack_cs3_n}, 16'h0000);
      check("oe dma", {15'h0, o_drq_cs2_oe}, 16'h0000);
      i_bus_dack_sa_n = 2'b01 << d;
      settle();
      check("dack hi", {15'h0, o_dack_cs3_n}, 16'h0001);
    end
    // chip selects: plain, qualified, blocked, extended decode
    i_drq_cs2_in = 1'b0;
    i_isa_addr = 12'h305;
    settle();
    check("cs0", {14'h0, o_io_chip_select_n}, 16'h0002);
    i_isa_addr = 12'h312;
    settle();
    check("cs1 idle", {14'h0, o_io_chip_select_n}, 16'h0003);
    i_ior_n = 1'b0;
    settle();
    check("cs1 rd", {14'h0, o_io_chip_select_n}, 16'h0001);
    i_ior_n = 1'b1;
    i_iow_n = 1'b0;
    settle();
    check("cs1 wr", {14'h0, o_io_chip_select_n}, 16'h0001);
    i_aen = 1'b1;
    settle();
    check("aen", {14'h0, o_io_chip_select_n}, 16'h0003);
    i_aen = 1'b0;
    i_iow_n = 1'b1;
    i_mode_select = MODE_EXT_INT;
    i_bus_dack_sa_n = 2'b11;
    i_isa_addr = 12'h200;
    settle();
    check("cs2", {14'h0, o_drq_cs2_oe, o_drq_cs2_n}, 16'h2);
    i_bus_dack_sa_n = 2'b01;
    settle();
    check("cs2 sa", {14'h0, o_drq_cs2_oe, o_drq_cs2_n}, 16'h3);
    i_bus_dack_sa_n = 2'b00;
    i_isa_addr = 12'h403;
    settle();
    check("cs3", {15'h0, o_dack_cs3_n}, 16'h0000);
    i_bus_dack_sa_n = 2'b11;
    i_isa_addr = 12'h305;
    settle();
    check("cs0 sa", {14'h0, o_io_chip_select_n}, 16'h0003);
    results();
  end
endmodule
